// file: hw/clk_cfg_defines.svh
// register offsets, field positions, reset values and page numbers of the clock configuration block
`ifndef CLK_CFG_DEFINES_SVH
`define CLK_CFG_DEFINES_SVH

`define OFS_PAGE_SELECT        7'h00
`define OFS_SOFT_RESET         7'h01
`define OFS_RSVD_TWO           7'h02
`define OFS_RSVD_THREE         7'h03
`define OFS_CLOCK_SOURCE       7'h04
`define OFS_PLL_POWER_DIV      7'h05
`define OFS_PLL_INTEGER        7'h06
`define OFS_PLL_FRAC_HIGH      7'h07
`define OFS_PLL_FRAC_LOW       7'h08

`define PAGE_CONTROL           8'h00
`define PAGE_ANALOG            8'h01
`define PAGE_COEF_LOW          8'h04
`define PAGE_COEF_HIGH         8'h05
`define PAGE_INSTR_FIRST       8'h20
`define PAGE_INSTR_LAST        8'h2F

`define RST_PAGE_SELECT        8'h00
`define RST_CLOCK_SOURCE       8'h00
`define RST_PLL_POWER          1'h0
`define RST_PLL_PRE_DIV        3'h1
`define RST_PLL_SEC_MULT       4'h1
`define RST_PLL_INTEGER        6'h04
`define RST_PLL_FRAC_HIGH      6'h00
`define RST_PLL_FRAC_LOW       8'h00

`define POS_SOFT_RESET         0
`define POS_LOOP_REF_LSB       2
`define POS_CORE_SRC_LSB       0
`define POS_PLL_POWER          7
`define POS_PLL_PRE_DIV_LSB    4
`define POS_PLL_SEC_MULT_LSB   0

`define COEF_WORDS             128
`define INSTR_WORDS            512
`define INSTR_PER_PAGE         32

`endif

// file: hw/clk_cfg_pkg.sv
// types shared by the clock configuration block
package clk_cfg_pkg;

	// clock source codes, 10 is reserved for both muxes
	typedef enum logic [1:0] {
		SRC_MASTER = 2'h0,
		SRC_BITCLK = 2'h1,
		SRC_RSVD   = 2'h2,
		SRC_THIRD  = 2'h3
	} clk_src_e;

	// settings handed to the loop and converter clock tree
	typedef struct packed {
		logic       power_up;
		logic [3:0] pre_divide;
		logic [4:0] secondary_mult;
		logic [5:0] integer_mult;
		logic [13:0] fractional_mult;
	} pll_cfg_s;

	// register access strobe from the control bus front end
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

endpackage

// file: hw/clk_cfg_top.sv
// paged register front end with clock source selection and loop multiplier settings
//
// Operation
// - eight-bit page select register, reset zero, picks page for later accesses
// - page 4 maps coefficients 0-63, page 5 maps coefficients 64-127
// - pages 32 to 47 map 512 instructions, 32 each, ascending
// - writing one to reset bit resets control registers, then self clears
// - loop reference select: master pin, bit clock pin, or constant low
// - core clock select: master pin, bit clock pin, or loop output
// - divider register top bit powers the loop up, resets to zero
// - pre-divider code 1-7 divides by that, code 0 by 8
// - secondary multiplier code 1-15 multiplies by that, 0 by 16
// - integer multiplier 1 to 63, reset 4, zero never written
// - fourteen-bit fractional multiplier split across high and low registers
// - fractional high part applies only when low part is written next
`timescale 1ns/1ps
`include "clk_cfg_defines.svh"

module clk_cfg_top (
	// clock, reset, enable
	input  wire logic                  ref_clk,
	input  wire logic                  arst_n,
	input  wire logic                  clk_en,
	// register access
	input  wire clk_cfg_pkg::reg_req_s req,
	output logic [7:0]                 rdata,
	output logic                       rvalid,
	// clock pins and loop output, taken unregistered as synchronous levels
	input  wire logic                  master_clk_pin,
	input  wire logic                  bit_clk_pin,
	input  wire logic                  loop_clk,
	// clock tree outputs
	output logic                       loop_reference_input,
	output logic                       converter_core_clock,
	output clk_cfg_pkg::pll_cfg_s      pll_cfg,
	// current page, for the rest of the device
	output logic [7:0]                 page_sel
);

	logic [7:0]  page_q;
	logic [1:0]  ref_src_q;
	logic [1:0]  core_src_q;
	logic        pll_power_q;
	logic [2:0]  pre_div_q;
	logic [3:0]  sec_mult_q;
	logic [5:0]  int_mult_q;
	logic [5:0]  frac_high_pend_q;
	logic [5:0]  frac_high_q;
	logic [7:0]  frac_low_q;
	logic        last_was_high_q;
	logic        soft_rst_q;
	logic [7:0]  coef_mem [0:`COEF_WORDS-1];
	logic [7:0]  instr_mem [0:`INSTR_WORDS-1];
	logic [7:0]  rdata_d;

	// a page number is mapped to storage only on the documented pages
	function automatic logic is_instr_page(input logic [7:0] pg);
		is_instr_page = (pg >= `PAGE_INSTR_FIRST) && (pg <= `PAGE_INSTR_LAST);
	endfunction

	// coefficient index: page 4 gives 0-63, page 5 gives 64-127
	// offsets above 63 alias onto the same page's words
	function automatic logic [6:0] coef_index(input logic [7:0] pg, input logic [6:0] ofs);
		coef_index = {(pg == `PAGE_COEF_HIGH), ofs[5:0]};
	endfunction

	// instruction index: 32 per page, page 32 holds 0-31
	function automatic logic [8:0] instr_index(input logic [7:0] pg, input logic [6:0] ofs);
		logic [7:0] rel;
		rel = pg - `PAGE_INSTR_FIRST;
		instr_index = {rel[3:0], ofs[4:0]};
	endfunction

	// control-page decode; writes elsewhere reach only the memories, the page select and the pairing flag
	logic ctrl_wr;
	logic on_page0;
	assign on_page0 = (page_q == `PAGE_CONTROL);
	assign ctrl_wr  = clk_en && req.wr && on_page0;

	// one write strobe per control register, shared by the processes below
	logic wr_soft;
	logic wr_src;
	logic wr_div;
	logic wr_int;
	logic wr_frac_high;
	logic wr_frac_low;
	assign wr_soft      = ctrl_wr && (req.addr == `OFS_SOFT_RESET);
	assign wr_src       = ctrl_wr && (req.addr == `OFS_CLOCK_SOURCE);
	assign wr_div       = ctrl_wr && (req.addr == `OFS_PLL_POWER_DIV);
	assign wr_int       = ctrl_wr && (req.addr == `OFS_PLL_INTEGER);
	assign wr_frac_high = ctrl_wr && (req.addr == `OFS_PLL_FRAC_HIGH);
	assign wr_frac_low  = ctrl_wr && (req.addr == `OFS_PLL_FRAC_LOW);

	// memory pages: offset zero stays the page register, so it never writes a word
	logic mem_wr;
	logic on_coef_page;
	logic on_instr_page;
	assign mem_wr        = clk_en && req.wr && (req.addr != `OFS_PAGE_SELECT);
	assign on_coef_page  = (page_q == `PAGE_COEF_LOW) || (page_q == `PAGE_COEF_HIGH);
	assign on_instr_page = is_instr_page(page_q);

	// self-clearing reset pulse; one clock later the control registers return to defaults
	// a write in the cycle after it is lost to the reset, so the host leaves a gap
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			soft_rst_q <= 1'b0;
		end else if (clk_en) begin
			soft_rst_q <= wr_soft && req.wdata[`POS_SOFT_RESET];
		end
	end

	// page select lives at offset zero on every page
	// written from any page, so the host can always get back to page zero
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			page_q <= `RST_PAGE_SELECT;
		end else if (clk_en) begin
			if (soft_rst_q) begin
				page_q <= `RST_PAGE_SELECT;
			end else if (req.wr && req.addr == `OFS_PAGE_SELECT) begin
				page_q <= req.wdata;
			end
		end
	end

	// loop reference select; upper nibble of the register is reserved and never stored
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ref_src_q <= 2'h0;
		end else if (clk_en) begin
			if (soft_rst_q) begin
				ref_src_q <= 2'h0;
			end else if (wr_src) begin
				ref_src_q <= req.wdata[`POS_LOOP_REF_LSB +: 2];
			end
		end
	end

	// converter core clock select, same register, independent field
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			core_src_q <= 2'h0;
		end else if (clk_en) begin
			if (soft_rst_q) begin
				core_src_q <= 2'h0;
			end else if (wr_src) begin
				core_src_q <= req.wdata[`POS_CORE_SRC_LSB +: 2];
			end
		end
	end

	// loop power; resets off so the loop only starts once the host has set it up
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pll_power_q <= `RST_PLL_POWER;
		end else if (clk_en) begin
			if (soft_rst_q) begin
				pll_power_q <= `RST_PLL_POWER;
			end else if (wr_div) begin
				pll_power_q <= req.wdata[`POS_PLL_POWER];
			end
		end
	end

	// pre-divider code, decoded to a ratio further down
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			pre_div_q <= `RST_PLL_PRE_DIV;
		end else if (clk_en) begin
			if (soft_rst_q) begin
				pre_div_q <= `RST_PLL_PRE_DIV;
			end else if (wr_div) begin
				pre_div_q <= req.wdata[`POS_PLL_PRE_DIV_LSB +: 3];
			end
		end
	end

	// secondary multiplier code, decoded the same way
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sec_mult_q <= `RST_PLL_SEC_MULT;
		end else if (clk_en) begin
			if (soft_rst_q) begin
				sec_mult_q <= `RST_PLL_SEC_MULT;
			end else if (wr_div) begin
				sec_mult_q <= req.wdata[`POS_PLL_SEC_MULT_LSB +: 4];
			end
		end
	end

	// integer multiplier; top two bits are reserved and dropped
	// a zero code is kept as written; keeping it out is the host's part
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			int_mult_q <= `RST_PLL_INTEGER;
		end else if (clk_en) begin
			if (soft_rst_q) begin
				int_mult_q <= `RST_PLL_INTEGER;
			end else if (wr_int) begin
				int_mult_q <= req.wdata[5:0];
			end
		end
	end

	// pairing flag: set by a high-part write, cleared by any other write on any page
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			last_was_high_q <= 1'b0;
		end else if (clk_en) begin
			if (soft_rst_q) begin
				last_was_high_q <= 1'b0;
			end else if (req.wr) begin
				last_was_high_q <= wr_frac_high;
			end
		end
	end

	// pending high part of the fraction, waiting for its low partner
	// a read of the high offset returns this pending value
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			frac_high_pend_q <= `RST_PLL_FRAC_HIGH;
		end else if (clk_en) begin
			if (soft_rst_q) begin
				frac_high_pend_q <= `RST_PLL_FRAC_HIGH;
			end else if (wr_frac_high) begin
				frac_high_pend_q <= req.wdata[5:0];
			end
		end
	end

	// applied fraction: the high part follows only when this low write pairs with it,
	// so the two halves of a pair reach the loop together; an unpaired low write changes the low half alone
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			frac_high_q <= `RST_PLL_FRAC_HIGH;
			frac_low_q  <= `RST_PLL_FRAC_LOW;
		end else if (clk_en) begin
			if (soft_rst_q) begin
				frac_high_q <= `RST_PLL_FRAC_HIGH;
				frac_low_q  <= `RST_PLL_FRAC_LOW;
			end else if (wr_frac_low) begin
				frac_low_q <= req.wdata;
				if (last_was_high_q) begin
					frac_high_q <= frac_high_pend_q;
				end
			end
		end
	end

	// coefficient memory; no reset, contents are loaded by the host
	always_ff @(posedge ref_clk) begin
		if (mem_wr && on_coef_page) begin
			coef_mem[coef_index(page_q, req.addr)] <= req.wdata;
		end
	end

	// instruction memory; offsets above 31 alias onto the same page's words
	always_ff @(posedge ref_clk) begin
		if (mem_wr && on_instr_page) begin
			instr_mem[instr_index(page_q, req.addr)] <= req.wdata;
		end
	end

	// read mux; reserved registers and unmapped pages read as zero
	// a read and a write in one cycle: the read sees the value before the write
	always_comb begin
		rdata_d = 8'h00;
		if (req.addr == `OFS_PAGE_SELECT) begin
			rdata_d = page_q;
		end else if (on_page0) begin
			unique case (req.addr)
				`OFS_CLOCK_SOURCE:  rdata_d = {4'h0, ref_src_q, core_src_q};
				`OFS_PLL_POWER_DIV: rdata_d = {pll_power_q, pre_div_q, sec_mult_q};
				`OFS_PLL_INTEGER:   rdata_d = {2'h0, int_mult_q};
				`OFS_PLL_FRAC_HIGH: rdata_d = {2'h0, frac_high_pend_q};
				`OFS_PLL_FRAC_LOW:  rdata_d = frac_low_q;
				default:            rdata_d = 8'h00;
			endcase
		end else if (on_coef_page) begin
			rdata_d = coef_mem[coef_index(page_q, req.addr)];
		end else if (on_instr_page) begin
			rdata_d = instr_mem[instr_index(page_q, req.addr)];
		end
	end

	// read answer flag, one clock after the strobe
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rvalid <= 1'b0;
		end else if (clk_en) begin
			rvalid <= req.rd;
		end
	end

	// read data registered with the strobe and held until the next read
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= 8'h00;
		end else if (clk_en && req.rd) begin
			rdata <= rdata_d;
		end
	end

	// loop reference mux; reserved and off codes hold a static low rather than a stray clock
	// the pins are taken as synchronous levels; no glitch-free switch is attempted
	always_comb begin
		unique case (clk_cfg_pkg::clk_src_e'(ref_src_q))
			clk_cfg_pkg::SRC_MASTER: loop_reference_input = master_clk_pin;
			clk_cfg_pkg::SRC_BITCLK: loop_reference_input = bit_clk_pin;
			default:                 loop_reference_input = 1'b0;
		endcase
	end

	// converter core clock mux; reserved code held low for the same reason
	always_comb begin
		unique case (clk_cfg_pkg::clk_src_e'(core_src_q))
			clk_cfg_pkg::SRC_MASTER: converter_core_clock = master_clk_pin;
			clk_cfg_pkg::SRC_BITCLK: converter_core_clock = bit_clk_pin;
			clk_cfg_pkg::SRC_THIRD:  converter_core_clock = loop_clk;
			default:                 converter_core_clock = 1'b0;
		endcase
	end

	// decoded loop settings: pre-divider and secondary multiplier code zero means the top of the range
	// decoded, not stored, so it matches what the registers read back, except a pending fraction high part
	always_comb begin
		pll_cfg.power_up        = pll_power_q;
		pll_cfg.pre_divide      = (pre_div_q == 3'h0) ? 4'h8 : {1'b0, pre_div_q};
		pll_cfg.secondary_mult  = (sec_mult_q == 4'h0) ? 5'h10 : {1'b0, sec_mult_q};
		pll_cfg.integer_mult    = int_mult_q;
		pll_cfg.fractional_mult = {frac_high_q, frac_low_q};
	end

	// page number exported for the rest of the device
	assign page_sel = page_q;

endmodule

// file: dv/clk_cfg_props.sv
// port assertions for the clock configuration block
`timescale 1ns/1ps
module clk_cfg_props (
	// clock and reset
	input wire logic                  ref_clk,
	input wire logic                  arst_n,
	input wire logic                  clk_en,
	// register access
	input wire clk_cfg_pkg::reg_req_s req,
	input wire logic [7:0]            rdata,
	input wire logic                  rvalid,
	// clock pins and tree
	input wire logic                  master_clk_pin,
	input wire logic                  bit_clk_pin,
	input wire logic                  loop_clk,
	input wire logic                  loop_reference_input,
	input wire logic                  converter_core_clock,
	input wire clk_cfg_pkg::pll_cfg_s pll_cfg,
	input wire logic [7:0]            page_sel
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// soft reset taken last enabled cycle; the write after it is overridden
	logic      rst_prev;
	wire       p0   = page_sel == 8'h00;
	wire [6:0] a    = req.addr;
	wire [7:0] d    = req.wdata;
	// accepted write that is not swallowed by the soft reset pulse
	wire       take = clk_en && req.wr && !rst_prev;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) rst_prev <= 1'b0;
		else if (clk_en) rst_prev <= req.wr && p0 && a == 7'h01 && d[0];
	end
	// steps of the fraction update and of the soft reset
	sequence s_hi; take && p0 && a == 7'h07; endsequence
	sequence s_lo; take && p0 && a == 7'h08; endsequence
	sequence s_rst; take && p0 && a == 7'h01 && d[0]; endsequence
	a_page_write: assert property (take && a == 7'h00 |=> page_sel == $past(d))
		else $error("page select not taken");
	a_read_answer: assert property (clk_en && req.rd |=> rvalid)
		else $error("read not answered");
	a_power_bit: assert property (take && p0 && a == 7'h05 |=> pll_cfg.power_up == $past(d[7]))
		else $error("power bit wrong");
	a_pre_div: assert property (take && p0 && a == 7'h05 && d[6:4] == 3'h0 |=> pll_cfg.pre_divide == 4'h8)
		else $error("pre divide code zero wrong");
	a_sec_mult: assert property (take && p0 && a == 7'h05 |=> pll_cfg.secondary_mult[3:0] == $past(d[3:0]))
		else $error("secondary multiplier wrong");
	a_int_mult: assert property (take && p0 && a == 7'h06 |=> pll_cfg.integer_mult == $past(d[5:0]))
		else $error("integer multiplier wrong");
	a_frac_pair: assert property (s_hi ##1 s_lo |=> pll_cfg.fractional_mult == {$past(d[5:0], 2), $past(d)})
		else $error("fraction pair not applied");
	a_frac_hold: assert property (s_hi |=> $stable(pll_cfg.fractional_mult))
		else $error("fraction high applied alone");
	a_soft_reset: assert property (s_rst |-> ##[1:3] (page_sel == 8'h00 && pll_cfg.integer_mult == 6'h04))
		else $error("soft reset missing");
	a_ref_static: assert property (loop_reference_input |-> master_clk_pin || bit_clk_pin)
		else $error("loop reference from no pin");
	a_core_src: assert property (converter_core_clock |-> master_clk_pin || bit_clk_pin || loop_clk)
		else $error("core clock from no source");
endmodule
bind clk_cfg_top clk_cfg_props u_clk_cfg_props (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
	.req(req), .rdata(rdata), .rvalid(rvalid), .master_clk_pin(master_clk_pin),
	.bit_clk_pin(bit_clk_pin), .loop_clk(loop_clk), .loop_reference_input(loop_reference_input),
	.converter_core_clock(converter_core_clock), .pll_cfg(pll_cfg), .page_sel(page_sel));

// file: dv/ctl_host.sv
// control bus host model issuing register requests
`timescale 1ns/1ps
module ctl_host (
	// clock
	input wire logic              ref_clk,
	// request to the device
	output clk_cfg_pkg::reg_req_s req
);
	logic [7:0] pg = 8'h00;
	initial req = '0;
	// called just after an edge, returns just after the edge that takes it
	task automatic xfer(input logic w, input logic r, input logic [6:0] a, input logic [7:0] d);
		// reserved bits go out as zero, only on the control page
		if (pg == 8'h00 && a == 7'h01) d = d & 8'h01;
		if (pg == 8'h00 && a == 7'h04) d = d & 8'h0F;
		if (pg == 8'h00 && (a == 7'h06 || a == 7'h07)) d = d & 8'h3F;
		if (pg == 8'h00 && a == 7'h06 && d[5:0] == 6'h00) d[0] = 1'b1;
		if (w && a == 7'h00) pg = d;
		req = '{w, r, a, d};
		@(posedge ref_clk);
		#1;
	endtask
endmodule

// file: dv/paged_clock_pll_config_tb_top.sv
// self-checking bench for the clock configuration block
`timescale 1ns/1ps
module paged_clock_pll_config_tb_top;
	logic                  ref_clk = 1'b0;
	logic                  arst_n = 1'b0;
	logic                  en = 1'b1;
	logic                  mclk = 1'b0;
	logic                  bclk = 1'b0;
	logic                  lclk = 1'b0;
	logic [7:0]            rdata, page_sel, v, hi, lo;
	logic                  rvalid, ref_in, core_clk;
	clk_cfg_pkg::reg_req_s req;
	clk_cfg_pkg::pll_cfg_s cfg;
	logic [7:0]            pg [4] = '{8'h04, 8'h05, 8'h20, 8'h2F};
	logic [7:0]            dat [4];
	integer                n_errors = 0, samples_checked = 0, i, seed = 32'h207325b7;
	always #5 ref_clk = ~ref_clk;
	ctl_host u_ctl_host (.ref_clk(ref_clk), .req(req));
	clk_cfg_top u_clk_cfg_top (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(en), .req(req),
		.rdata(rdata), .rvalid(rvalid), .master_clk_pin(mclk), .bit_clk_pin(bclk),
		.loop_clk(lclk), .loop_reference_input(ref_in), .converter_core_clock(core_clk),
		.pll_cfg(cfg), .page_sel(page_sel));
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d); u_ctl_host.xfer(1, 0, a, d); endtask
	task automatic idle; u_ctl_host.xfer(0, 0, 7'h00, 8'h00); endtask
	// read answers one cycle later, so it is caught right on return
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		u_ctl_host.xfer(0, 1, a, 8'h00);
		cmp("rvalid", 1, rvalid);
		d = rdata;
	endtask
	function automatic logic [3:0] pre_exp(input logic [2:0] c); return c == 0 ? 4'h8 : 4'(c); endfunction
	function automatic logic [4:0] sec_exp(input logic [3:0] c); return c == 0 ? 5'h10 : 5'(c); endfunction
	// mux model: code 10 is reserved and must sit low
	function automatic logic src_exp(input logic [1:0] c, input logic m, b, t);
		return c == 0 ? m : c == 1 ? b : c == 3 ? t : 1'b0;
	endfunction
	task automatic complete_run;
		if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// watchdog at 10000 cycles, far beyond the roughly 75 cycles the tests need
	initial begin
		#100000;
		n_errors++;
		complete_run;
	end
	initial begin
		repeat (3) @(posedge ref_clk);
		#1 arst_n = 1'b1;
		@(posedge ref_clk);
		#1;
		for (i = 0; i < 9; i++) if (i != 3) begin
			rd(i[6:0], v);
			cmp("reset read", i == 5 ? 8'h11 : i == 6 ? 8'h04 : 8'h00, v);
		end
		cmp("cfg reset", {1'b0, 4'h1, 5'h01, 6'h04, 14'h0000}, cfg);
		for (i = 0; i < 4; i++) begin
			wr(7'h04, {4'h0, i[1:0], i[1:0]});
			repeat (4) begin
				{mclk, bclk, lclk} = 3'($random(seed));
				#1;
				cmp("loop ref", src_exp(i[1:0], mclk, bclk, 1'b0), ref_in);
				cmp("core clk", src_exp(i[1:0], mclk, bclk, lclk), core_clk);
				@(posedge ref_clk);
				#1;
			end
		end
		// divider codes: zero codes first, then random
		for (i = 0; i < 9; i++) begin
			v = i == 0 ? 8'h80 : 8'($random(seed));
			wr(7'h05, v);
			cmp("power", v[7], cfg.power_up);
			cmp("pre div", pre_exp(v[6:4]), cfg.pre_divide);
			cmp("sec mult", sec_exp(v[3:0]), cfg.secondary_mult);
		end
		v = {2'h0, 6'($random(seed))} | 8'h01;
		wr(7'h06, v);
		rd(7'h06, lo);
		cmp("integer", v, lo);
		cmp("integer cfg", v[5:0], cfg.integer_mult);
		// enable low freezes state: this write must not land
		en = 1'b0;
		wr(7'h06, ~v);
		en = 1'b1;
		cmp("enable hold", v[5:0], cfg.integer_mult);
		hi = {2'h0, 6'($random(seed))};
		lo = 8'($random(seed));
		wr(7'h07, hi);
		cmp("frac held", 0, cfg.fractional_mult);
		wr(7'h08, lo);
		cmp("frac pair", {hi[5:0], lo}, cfg.fractional_mult);
		// a write in between breaks the pairing; low part still lands
		wr(7'h07, hi ^ 8'h15);
		wr(7'h06, v);
		wr(7'h08, ~lo);
		cmp("frac unpaired", {hi[5:0], ~lo}, cfg.fractional_mult);
		for (i = 0; i < 4; i++) begin
			dat[i] = 8'($random(seed));
			wr(7'h00, pg[i]);
			cmp("page", pg[i], page_sel);
			wr(7'h05, dat[i]);
		end
		for (i = 0; i < 4; i++) begin
			wr(7'h00, pg[i]);
			rd(7'h05, v);
			cmp("ram", dat[i], v);
		end
		wr(7'h00, 8'h00);
		wr(7'h05, 8'h80);
		wr(7'h01, 8'h00);
		idle;
		cmp("reset zero", 1, cfg.power_up);
		wr(7'h01, 8'h01);
		repeat (3) idle;
		cmp("soft reset", {1'b0, 4'h1, 5'h01, 6'h04, 14'h0000}, cfg);
		cmp("page reset", 0, page_sel);
		rd(7'h04, v);
		cmp("source reset", 0, v);
		complete_run;
	end
endmodule
